// *** rtl/pms_pkg.sv ***
// Package: constants and types of the program memory space controller
package pms_pkg;

  // ----------------------------------------------------------------
  // Register map (word offsets on the Wishbone bus)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_MEM_SIZE_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_MEM_SIZE_UNLOCK = 4'h1;
  localparam logic [3:0] ADDR_SEGMENTS        = 4'h2;
  localparam logic [3:0] ADDR_IRQ_STATUS      = 4'h3;
  localparam logic [3:0] ADDR_IRQ_MASK        = 4'h4;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int         LARGE_PROG_BIT       = 1;
  localparam logic [7:0] MSC_RESET            = 8'h00;
  localparam logic [7:0] MSC_FIXED_ONES       = 8'hfc;
  localparam logic [3:0] UNLOCK_FIRST         = 4'h5;
  localparam logic [3:0] UNLOCK_SECOND        = 4'ha;
  localparam logic [16:0] INT_ROM_LAST        = 17'h0ffff;

  // Reset vectors
  localparam logic [15:0] VEC_PIN_RESET       = 16'h0000;
  localparam logic [15:0] VEC_BREAK_RESET     = 16'h0002;
  localparam logic [15:0] VEC_WDT_RESET       = 16'h0004;
  localparam logic [15:0] VEC_TRAP_RESET      = 16'h0006;

  // Interrupt status bits
  localparam int IRQ_TRAP   = 0;
  localparam int IRQ_LOCKED = 1;
  localparam int IRQ_WIDTH  = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    UNL_IDLE  = 2'b00,
    UNL_ARMED = 2'b01,
    UNL_OPEN  = 2'b10
  } pms_unlock_state_t;

  typedef struct packed
  {
    logic        valid;
    logic        table_ref;
    logic [15:0] offset;
  } pms_fetch_req_t;

  typedef struct packed
  {
    logic [16:0] addr;
    logic        to_external;
  } pms_fetch_route_t;

  typedef struct packed
  {
    logic [7:0] ad_low;
    logic       ad_low_oe;
    logic [7:0] addr_mid;
    logic       addr_top;
    logic       latch;
    logic       program_fetch_strobe;
  } pms_ext_bus_t;

endpackage

// *** rtl/pms_ctrl.sv ***
// Program memory space control: size register, unlock, segments, fetch routing
`timescale 1ns/100ps

module pms_ctrl
  import pms_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Reset sources
  input  wire logic             ext_reset_i,
  input  wire logic             break_reset_i,
  input  wire logic             wdt_reset_i,
  // Wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [5:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // Core events
  input  wire logic             instr_done_i,
  input  wire logic             far_jump_i,
  input  wire logic             far_call_i,
  input  wire logic             far_return_i,
  input  wire logic             far_target_seg_i,
  input  wire logic             vector_take_i,
  input  wire logic             is_interrupt_i,
  input  wire logic [15:0]      vector_addr_i,
  input  wire logic             interrupt_return_i,
  input  wire logic             stacked_seg_i,
  input  wire logic [7:0]       rom_byte_i,
  input  wire logic             rom_byte_valid_i,
  // Fetch path
  input  wire pms_fetch_req_t   fetch_i,
  input  wire logic             external_program_select_i,
  output pms_fetch_route_t      route_o,
  output pms_ext_bus_t          ext_bus_o,
  // Vector and segment state
  output logic [15:0]           pc_load_o,
  output logic                  pc_load_valid_o,
  output logic                  push_segment_o,
  output logic                  code_segment_o,
  output logic                  large_active_o,
  output logic                  trap_reset_o,
  output logic                  irq_o
);

  // ----------------------------------------------------------------
  // Reset aggregation and pin synchroniser
  // ----------------------------------------------------------------
  logic       ea_meta_reg;
  logic       ea_sync_reg;
  logic       trap_reset_reg;
  logic       any_reset;

  always_ff @(posedge clk_i)
  begin
    ea_meta_reg <= external_program_select_i;
    ea_sync_reg <= ea_meta_reg;
  end

  assign any_reset = rst_i | ext_reset_i | break_reset_i | wdt_reset_i | trap_reset_reg;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic       bus_req;
  logic       wr_ctrl;
  logic       wr_unlock;
  logic       wr_seg;
  logic       wr_status;
  logic       wr_mask;
  logic [3:0] word_adr;

  assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign word_adr  = wb_adr_i[5:2];
  assign wr_ctrl   = bus_req & wb_we_i & wb_sel_i[0] & (word_adr == ADDR_MEM_SIZE_CTRL);
  assign wr_unlock = bus_req & wb_we_i & wb_sel_i[0] & (word_adr == ADDR_MEM_SIZE_UNLOCK);
  assign wr_seg    = bus_req & wb_we_i & wb_sel_i[0] & (word_adr == ADDR_SEGMENTS);
  assign wr_status = bus_req & wb_we_i & wb_sel_i[0] & (word_adr == ADDR_IRQ_STATUS);
  assign wr_mask   = bus_req & wb_we_i & wb_sel_i[0] & (word_adr == ADDR_IRQ_MASK);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= bus_req;
  end

  // ----------------------------------------------------------------
  // Unlock sequence
  // ----------------------------------------------------------------
  pms_unlock_state_t unlock_reg;

  // Lower nibble is not stored at all, so its content never matters
  always_ff @(posedge clk_i)
  begin
    if (any_reset)
      unlock_reg <= UNL_IDLE;
    else if (wr_unlock)
    begin
      unique case (unlock_reg)
        UNL_IDLE:  unlock_reg <= (wb_dat_i[7:4] == UNLOCK_FIRST) ? UNL_ARMED : UNL_IDLE;
        UNL_ARMED: unlock_reg <= (wb_dat_i[7:4] == UNLOCK_SECOND) ? UNL_OPEN
                               : (wb_dat_i[7:4] == UNLOCK_FIRST) ? UNL_ARMED : UNL_IDLE;
        UNL_OPEN:  unlock_reg <= (wb_dat_i[7:4] == UNLOCK_FIRST) ? UNL_ARMED : UNL_IDLE;
        default:   unlock_reg <= UNL_IDLE;
      endcase
    end
    else if (wr_ctrl)
      unlock_reg <= UNL_IDLE;
  end

  // ----------------------------------------------------------------
  // Size control register, write-once
  // ----------------------------------------------------------------
  logic large_reg;
  logic written_reg;
  logic pending_reg;
  logic large_active_reg;
  logic ctrl_accept;

  assign ctrl_accept = wr_ctrl & ~written_reg;

  always_ff @(posedge clk_i)
  begin
    if (any_reset)
    begin
      large_reg   <= MSC_RESET[LARGE_PROG_BIT];
      written_reg <= 1'b0;
    end
    else if (ctrl_accept)
    begin
      written_reg <= 1'b1;
      if (unlock_reg == UNL_OPEN)
        large_reg <= wb_dat_i[LARGE_PROG_BIT];
    end
  end

  // Expansion waits for two instruction completions: the write's and the next one
  logic [1:0] settle_reg;

  always_ff @(posedge clk_i)
  begin
    if (any_reset)
    begin
      large_active_reg <= 1'b0;
      pending_reg      <= 1'b0;
      settle_reg       <= 2'h0;
    end
    else if (ctrl_accept && unlock_reg == UNL_OPEN)
    begin
      pending_reg      <= wb_dat_i[LARGE_PROG_BIT];
      settle_reg       <= 2'h0;
      if (!wb_dat_i[LARGE_PROG_BIT])
        large_active_reg <= 1'b0;
    end
    else if (pending_reg && instr_done_i)
    begin
      if (settle_reg == 2'h1)
      begin
        large_active_reg <= 1'b1;
        pending_reg      <= 1'b0;
      end
      settle_reg <= settle_reg + 2'h1;
    end
  end

  assign large_active_o = large_active_reg;

  // ----------------------------------------------------------------
  // Opcode trap on far transfer in the small model
  // ----------------------------------------------------------------
  logic far_op;

  assign far_op = far_jump_i | far_call_i | far_return_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i | trap_reset_reg)
      trap_reset_reg <= 1'b0;
    else
      trap_reset_reg <= far_op & ~large_active_reg;
  end

  assign trap_reset_o = trap_reset_reg;

  // ----------------------------------------------------------------
  // Segments and vector load
  // ----------------------------------------------------------------
  logic       code_seg_reg;
  logic       table_seg_reg;
  logic       vec_busy_reg;
  logic       vec_high_reg;
  logic [7:0] vec_low_reg;
  logic [15:0] vec_addr_reg;
  logic       reset_pend_reg;
  logic [15:0] reset_vec_reg;
  logic [1:0]  vec_guard_reg;
  logic        vec_byte_ok;

  // A byte only counts once the routed address has had time to reach the memory and come back
  assign vec_byte_ok = vec_busy_reg & rom_byte_valid_i & (vec_guard_reg == 2'h0);

  // Remember which reset source fired so the vector fetch can follow release
  always_ff @(posedge clk_i)
  begin
    if (rst_i | ext_reset_i)
    begin
      reset_pend_reg <= 1'b1;
      reset_vec_reg  <= VEC_PIN_RESET;
    end
    else if (break_reset_i)
    begin
      reset_pend_reg <= 1'b1;
      reset_vec_reg  <= VEC_BREAK_RESET;
    end
    else if (wdt_reset_i)
    begin
      reset_pend_reg <= 1'b1;
      reset_vec_reg  <= VEC_WDT_RESET;
    end
    else if (trap_reset_reg)
    begin
      reset_pend_reg <= 1'b1;
      reset_vec_reg  <= VEC_TRAP_RESET;
    end
    else if (!vec_busy_reg)
      reset_pend_reg <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (any_reset)
    begin
      vec_busy_reg <= 1'b0;
      vec_high_reg <= 1'b0;
      vec_low_reg  <= 8'h00;
      vec_addr_reg  <= 16'h0000;
      vec_guard_reg <= 2'h0;
    end
    else if (!vec_busy_reg && (reset_pend_reg || vector_take_i))
    begin
      vec_busy_reg  <= 1'b1;
      vec_high_reg  <= 1'b0;
      vec_guard_reg <= 2'h2;
      vec_addr_reg  <= reset_pend_reg ? reset_vec_reg : {vector_addr_i[15:1], 1'b0};
    end
    else if (vec_byte_ok)
    begin
      if (!vec_high_reg)
      begin
        vec_low_reg   <= rom_byte_i;
        vec_high_reg  <= 1'b1;
        vec_guard_reg <= 2'h2;
      end
      else
        vec_busy_reg <= 1'b0;
    end
    else if (vec_guard_reg != 2'h0)
      vec_guard_reg <= vec_guard_reg - 2'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (any_reset)
    begin
      pc_load_o       <= 16'h0000;
      pc_load_valid_o <= 1'b0;
    end
    else
    begin
      pc_load_valid_o <= vec_high_reg & vec_byte_ok;
      if (vec_high_reg && vec_byte_ok)
        pc_load_o <= {rom_byte_i, vec_low_reg};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (any_reset)
      push_segment_o <= 1'b0;
    else
      push_segment_o <= vector_take_i & is_interrupt_i & ~vec_busy_reg & large_active_reg;
  end

  always_ff @(posedge clk_i)
  begin
    if (any_reset)
    begin
      code_seg_reg  <= 1'b0;
      table_seg_reg <= 1'b0;
    end
    else
    begin
      if (vec_busy_reg)
        code_seg_reg <= 1'b0;
      else if (interrupt_return_i && large_active_reg)
        code_seg_reg <= stacked_seg_i;
      else if ((far_jump_i || far_call_i || far_return_i) && large_active_reg)
        code_seg_reg <= far_target_seg_i;
      else if (wr_seg && large_active_reg)
        code_seg_reg <= wb_dat_i[0];
      if (wr_seg)
        table_seg_reg <= wb_dat_i[1] & large_active_reg;
    end
  end

  assign code_segment_o = code_seg_reg;

  // ----------------------------------------------------------------
  // Fetch routing and external bus
  // ----------------------------------------------------------------
  logic [16:0] fetch_addr;
  logic        seg_sel;

  always_comb
  begin
    seg_sel = fetch_i.table_ref ? table_seg_reg : code_seg_reg;
    if (vec_busy_reg)
      fetch_addr = {1'b0, vec_addr_reg[15:1], vec_high_reg};
    else
      fetch_addr = {seg_sel & large_active_reg, fetch_i.offset};
  end

  always_ff @(posedge clk_i)
  begin
    if (any_reset)
    begin
      route_o   <= '0;
      ext_bus_o <= '0;
    end
    else
    begin
      route_o.addr        <= fetch_addr;
      route_o.to_external <= ~ea_sync_reg | (fetch_addr > INT_ROM_LAST);
      if ((fetch_i.valid || vec_busy_reg) && (!ea_sync_reg || fetch_addr > INT_ROM_LAST))
      begin
        ext_bus_o.ad_low               <= fetch_addr[7:0];
        ext_bus_o.ad_low_oe            <= 1'b1;
        ext_bus_o.addr_mid             <= fetch_addr[15:8];
        ext_bus_o.addr_top             <= fetch_addr[16];
        ext_bus_o.latch                <= 1'b1;
        ext_bus_o.program_fetch_strobe <= 1'b1;
      end
      else
      begin
        ext_bus_o.ad_low_oe            <= 1'b0;
        ext_bus_o.latch                <= 1'b0;
        ext_bus_o.program_fetch_strobe <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  logic [IRQ_WIDTH-1:0] irq_status_reg;
  logic [IRQ_WIDTH-1:0] irq_mask_reg;
  logic [IRQ_WIDTH-1:0] irq_set;

  assign irq_set[IRQ_TRAP]   = trap_reset_reg;
  assign irq_set[IRQ_LOCKED] = wr_ctrl & written_reg;

  // Status survives core resets so software can see why it restarted
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_status_reg <= '0;
      irq_mask_reg   <= '0;
    end
    else
    begin
      irq_status_reg <= (irq_status_reg & ~(wr_status ? wb_dat_i[IRQ_WIDTH-1:0] : '0)) | irq_set;
      if (wr_mask)
        irq_mask_reg <= wb_dat_i[IRQ_WIDTH-1:0];
    end
  end

  assign irq_o = |(irq_status_reg & irq_mask_reg);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (bus_req && !wb_we_i)
    begin
      unique case (word_adr)
        ADDR_MEM_SIZE_CTRL:   wb_dat_o <= {24'h000000, MSC_FIXED_ONES | {6'h00, large_reg, 1'b0}};
        ADDR_MEM_SIZE_UNLOCK: wb_dat_o <= {30'h00000000, unlock_reg};
        ADDR_SEGMENTS:        wb_dat_o <= {29'h00000000, large_active_reg, table_seg_reg, code_seg_reg};
        ADDR_IRQ_STATUS:      wb_dat_o <= {30'h00000000, irq_status_reg};
        ADDR_IRQ_MASK:        wb_dat_o <= {30'h00000000, irq_mask_reg};
        default:              wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_small_after_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(any_reset) |-> !large_active_reg)
    else $error("expansion active right after reset");

  a_trap_on_far: assert property (@(posedge clk_i) disable iff (rst_i)
    (far_op && !large_active_reg && !any_reset) |=> trap_reset_reg)
    else $error("far op in small model without trap");

  a_write_once: assert property (@(posedge clk_i) disable iff (rst_i)
    (written_reg && !any_reset) |=> $stable(large_reg))
    else $error("size register changed after first write");

  a_read_fixed: assert property (@(posedge clk_i) disable iff (rst_i)
    (bus_req && !wb_we_i && word_adr == ADDR_MEM_SIZE_CTRL) |=> (wb_dat_o[7:2] == 6'h3f && !wb_dat_o[0]))
    else $error("fixed bits of size register wrong");

  a_unlock_needed: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_accept && unlock_reg != UNL_OPEN && !any_reset) |=> $stable(large_reg))
    else $error("enable changed without unlock");

  a_unlock_abort: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_unlock && unlock_reg == UNL_ARMED && wb_dat_i[7:4] != UNLOCK_SECOND && !any_reset)
      |=> unlock_reg != UNL_OPEN)
    else $error("unlock opened by wrong value");

  a_vec_clears_seg: assert property (@(posedge clk_i) disable iff (rst_i)
    vec_busy_reg |=> !code_seg_reg)
    else $error("code segment not cleared on vector load");

  a_ea_low_ext: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ea_sync_reg && !any_reset) |=> route_o.to_external)
    else $error("internal fetch with external select low");

  a_delayed_expand: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_accept && unlock_reg == UNL_OPEN && !any_reset) |=> !large_active_reg)
    else $error("expansion applied at once");

endmodule

// *** verification/pms_rom_model.sv ***
// External program memory model that serves bytes for the routed address
`timescale 1ns/100ps
module pms_rom_model
  import pms_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Pacing, in cycles between served bytes
  input  wire logic [3:0]       gap_i,
  // Address side
  input  wire pms_fetch_route_t route_i,
  // Data side
  output logic      [7:0]       rom_byte_o,
  output logic                  rom_byte_valid_o
);
  // ----------------------------------------------------------------
  // Byte server
  // ----------------------------------------------------------------
  logic [3:0] wait_reg;

  // Free running: bytes outside a vector load must be ignored by the device
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wait_reg         <= 4'h0;
      rom_byte_valid_o <= 1'b0;
      rom_byte_o       <= 8'h00;
    end
    else if (wait_reg >= gap_i)
    begin
      wait_reg         <= 4'h0;
      rom_byte_valid_o <= 1'b1;
      rom_byte_o       <= route_i.addr[7:0] ^ 8'h5a;
    end
    else
    begin
      wait_reg         <= wait_reg + 4'h1;
      rom_byte_valid_o <= 1'b0;
      // Data is not held once the strobe is gone
      rom_byte_o       <= ~rom_byte_o;
    end
  end
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the program memory space controller
`timescale 1ns/100ps
module tb;
  import pms_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [5:0] A_CTL = {ADDR_MEM_SIZE_CTRL, 2'b00};
  localparam logic [5:0] A_UNL = {ADDR_MEM_SIZE_UNLOCK, 2'b00};
  localparam logic [5:0] A_SEG = {ADDR_SEGMENTS, 2'b00};
  localparam logic [5:0] A_STA = {ADDR_IRQ_STATUS, 2'b00};
  localparam logic [5:0] A_MSK = {ADDR_IRQ_MASK, 2'b00};
  logic clk_i, rst_i, ext_reset_i, break_reset_i, wdt_reset_i;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [5:0] wb_adr_i;
  logic [3:0] wb_sel_i, gap;
  logic [31:0] wb_dat_i, wb_dat_o, rdat;
  logic instr_done_i, far_jump_i, far_call_i, far_return_i, far_target_seg_i;
  logic vector_take_i, is_interrupt_i, interrupt_return_i, stacked_seg_i;
  logic [15:0] vector_addr_i, pc_load_o, pc_seen;
  logic [7:0] rom_byte_i;
  logic rom_byte_valid_i, external_program_select_i, pc_load_valid_o;
  logic push_segment_o, code_segment_o, large_active_o, trap_reset_o, irq_o;
  pms_fetch_req_t fetch_i;
  pms_fetch_route_t route_o;
  pms_ext_bus_t ext_bus_o;
  int miscompares = 0, num_checks = 0, pc_cnt = 0, push_cnt = 0, trap_cnt = 0, n0;
  int ev[6] = '{6, 7, 8, 1, 2, 3};
  logic [15:0] vec[6] = '{VEC_PIN_RESET, VEC_BREAK_RESET, VEC_WDT_RESET,
                          VEC_TRAP_RESET, VEC_TRAP_RESET, VEC_TRAP_RESET};

  pms_ctrl dut (.clk_i, .rst_i, .ext_reset_i, .break_reset_i, .wdt_reset_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .instr_done_i, .far_jump_i,
    .far_call_i, .far_return_i, .far_target_seg_i, .vector_take_i, .is_interrupt_i, .vector_addr_i,
    .interrupt_return_i, .stacked_seg_i, .rom_byte_i, .rom_byte_valid_i, .fetch_i,
    .external_program_select_i, .route_o, .ext_bus_o, .pc_load_o, .pc_load_valid_o, .push_segment_o,
    .code_segment_o, .large_active_o, .trap_reset_o, .irq_o);
  pms_rom_model rom (.clk_i, .rst_i, .gap_i(gap), .route_i(route_o), .rom_byte_o(rom_byte_i),
    .rom_byte_valid_o(rom_byte_valid_i));

  always #2 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // Monitors and tasks
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (pc_load_valid_o === 1'b1)
    begin
      pc_seen <= pc_load_o;
      pc_cnt  <= pc_cnt + 1;
    end
    if (push_segment_o === 1'b1)
      push_cnt <= push_cnt + 1;
    if (trap_reset_o === 1'b1)
      trap_cnt <= trap_cnt + 1;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic xfer(input logic we, input logic [5:0] adr, input logic [31:0] wd);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_sel_i <= 4'hf;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1)
        break;
    end
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (n == 50)
      chk(0, 1, "bus timeout");
    if (n == 50)
      give_verdict();
  endtask

  task automatic wr(input logic [5:0] adr, input logic [31:0] d);
    xfer(1'b1, adr, d);
  endtask

  task automatic rd(input logic [5:0] adr, input logic [31:0] exp, input string what);
    xfer(1'b0, adr, 32'h0);
    chk(rdat, exp, what);
  endtask

  task automatic pulse(input int k);
    @(posedge clk_i);
    case (k)
      0: instr_done_i <= 1'b1;
      1: far_jump_i <= 1'b1;
      2: far_call_i <= 1'b1;
      3: far_return_i <= 1'b1;
      4: vector_take_i <= 1'b1;
      5: interrupt_return_i <= 1'b1;
      6: ext_reset_i <= 1'b1;
      7: break_reset_i <= 1'b1;
      default: wdt_reset_i <= 1'b1;
    endcase
    @(posedge clk_i);
    {instr_done_i, far_jump_i, far_call_i, far_return_i, vector_take_i} <= '0;
    {interrupt_return_i, ext_reset_i, break_reset_i, wdt_reset_i} <= '0;
  endtask

  // Expected vector: low byte at the even address, high byte at the odd one
  task automatic wait_pc(input logic [15:0] v, input string what);
    int c;
    c = pc_cnt;
    for (int i = 0; i < 400 && pc_cnt == c; i++)
      @(posedge clk_i);
    if (pc_cnt == c)
      chk(0, 1, "vector timeout");
    if (pc_cnt == c)
      give_verdict();
    chk(32'(pc_seen), {16'h0, v[7:0] ^ 8'h5b, v[7:0] ^ 8'h5a}, what);
  endtask

  task automatic enable_large;
    wr(A_UNL, 32'h50);
    wr(A_UNL, 32'ha0);
    wr(A_CTL, 32'h02);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (50000) @(posedge clk_i);
    chk(0, 1, "run timeout");
    give_verdict();
  end

  initial
  begin
    {clk_i, rst_i, gap, wb_sel_i} = {1'b0, 1'b1, 4'h3, 4'hf};
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    {instr_done_i, far_jump_i, far_call_i, far_return_i, far_target_seg_i} = '0;
    {vector_take_i, is_interrupt_i, vector_addr_i, interrupt_return_i, stacked_seg_i} = '0;
    {ext_reset_i, break_reset_i, wdt_reset_i, fetch_i} = '0;
    external_program_select_i = 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_pc(VEC_PIN_RESET, "pin reset vector");
    rd(A_CTL, 32'hfc, "size after reset");
    chk(large_active_o, 0, "small model");
    wr(A_UNL, 32'h50);
    rd(A_UNL, 32'h1, "armed");
    wr(A_UNL, 32'h30);
    rd(A_UNL, 32'h0, "sequence abandoned");
    wr(A_UNL, 32'h5f);
    rd(A_UNL, 32'h1, "low bits ignored");
    wr(A_UNL, 32'ha0);
    wr(A_CTL, 32'hff);
    rd(A_CTL, 32'hfe, "large enabled");
    pulse(0);
    repeat (2) @(posedge clk_i);
    chk(large_active_o, 0, "one instruction later");
    pulse(0);
    repeat (2) @(posedge clk_i);
    chk(large_active_o, 1, "two instructions later");
    $display("test unlock done");
    enable_large();
    rd(A_CTL, 32'hfe, "second write");
    rd(A_STA, 32'h2, "locked write flag");
    rd(A_MSK, 32'h0, "mask reset");
    chk(irq_o, 0, "masked");
    wr(A_MSK, 32'h2);
    @(posedge clk_i);
    chk(irq_o, 1, "unmasked");
    wr(A_STA, 32'h2);
    @(posedge clk_i);
    chk(irq_o, 0, "cleared");
    rd(6'h3c, 32'h0, "unmapped");
    $display("test irq done");
    wr(A_SEG, 32'h1);
    @(posedge clk_i);
    chk(code_segment_o, 1, "code segment");
    far_target_seg_i <= 1'b1;
    n0 = trap_cnt;
    pulse(1);
    repeat (4) @(posedge clk_i);
    chk(trap_cnt - n0, 0, "far jump allowed");
    fetch_i <= '{1'b1, 1'b0, 16'h1234};
    repeat (3) @(posedge clk_i);
    chk(32'(route_o), 32'({17'h11234, 1'b1}), "segment 1 fetch");
    chk({ext_bus_o.addr_mid, 7'h0, ext_bus_o.addr_top}, 16'h1201, "bus address");
    chk({ext_bus_o.ad_low, ext_bus_o.ad_low_oe, ext_bus_o.latch, ext_bus_o.program_fetch_strobe},
      11'h1a7, "bus strobes");
    fetch_i.table_ref <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(32'(route_o), 32'({17'h01234, 1'b0}), "table fetch");
    external_program_select_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk(32'(route_o), 32'({17'h01234, 1'b1}), "internal masked");
    external_program_select_i <= 1'b1;
    fetch_i <= '0;
    $display("test route done");
    for (int k = 0; k < 2; k++)
    begin
      vector_addr_i <= k ? 16'h006a : 16'h000a;
      is_interrupt_i <= 1'b1;
      n0 = push_cnt;
      pulse(4);
      wait_pc(k ? 16'h006a : 16'h000a, "interrupt vector");
      chk(push_cnt - n0, 1, "segment pushed");
      chk(code_segment_o, 0, "segment cleared");
      stacked_seg_i <= 1'b1;
      pulse(5);
      @(posedge clk_i);
      chk(code_segment_o, 1, "segment restored");
    end
    $display("test vector done");
    gap <= 4'h9;
    for (int k = 0; k < 6; k++)
    begin
      n0 = trap_cnt;
      pulse(ev[k]);
      wait_pc(vec[k], "reset vector");
      rd(A_CTL, 32'hfc, "size after reset");
      chk(large_active_o, 0, "small after reset");
      if (k == 2)
        wr(A_CTL, 32'h02);
      if (k == 2)
        rd(A_CTL, 32'hfc, "write without unlock");
      if (k >= 3)
        chk(trap_cnt - n0, 1, "far op trap");
      if (k >= 3)
        rd(A_STA, 32'h1, "trap flag");
      if (k < 2)
        enable_large();
      if (k < 2)
        rd(A_CTL, 32'hfe, "write after reset");
    end
    $display("test reset done");
    give_verdict();
  end
endmodule
